/* logic/css_pkg.sv */
// Shared constants and carrier types of the clock and supply supervision block.
// Assumes a 32-bit AXI4-Lite register bus and 13-bit non-volatile option words.
`default_nettype none
package css_pkg;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFF_PORT8 = 32'h0000_0004;
  localparam logic [31:0] OFF_WAKE = 32'h0000_0008;
  localparam logic [31:0] OFF_MASK = 32'h0000_000c;
  localparam logic [31:0] OFF_IRQSTAT = 32'h0000_0010;
  localparam logic [31:0] OFF_CFG = 32'h0000_0014;
  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_EN_BIT = 2;
  localparam int unsigned PORT8_EN_BIT = 7;
  localparam int unsigned PORT8_OKN_BIT = 6;
  localparam int unsigned WAKE_FLAG_BIT = 6;
  localparam int unsigned WAKE_WE_BIT = 5;
  localparam int unsigned MASK_IE_BIT = 6;
  localparam int unsigned W0_LVR_LSB = 9;
  localparam int unsigned W0_OSC_LSB = 4;
  localparam int unsigned W1_RCM_LSB = 0;
  // ==========================================================================
  // Reset values and write masks
  localparam logic [7:0] CTRL_RST = 8'h03;
  localparam logic [7:0] WAKE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] WAKE_RW_MASK = 8'h38;
  localparam logic [7:0] MASK_RW_MASK = 8'hfc;
  localparam logic [2:0] OSC_DEFAULT = 3'h7;
  localparam logic [1:0] RCM_DEFAULT = 2'h3;
  localparam logic [1:0] LVR_DEFAULT = 2'h3;
  localparam logic [1:0] OPT_SETTLE = 2'h2;
  // ==========================================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    CSS_ERC = 4'h1,
    CSS_IRC = 4'h2,
    CSS_LXT = 4'h4,
    CSS_HXT = 4'h8
  } css_osc_mode_t;
  typedef struct packed {
    css_osc_mode_t mode;
    logic clkOnPinA;
    logic pinAGpio;
    logic pinBGpio;
  } css_clk_cfg_t;
  typedef struct packed {
    logic enable;
    logic [12:0] levelMv;
  } css_brownout_t;
  typedef struct packed {
    logic [12:0] word0;
    logic [12:0] word1;
  } css_options_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] prot;
  } css_ax_t;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } css_w_t;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } css_r_t;
endpackage
`default_nettype wire

/* logic/css_top.sv */
// Clock option decode, brownout level decode and low supply detector with its
// AXI4-Lite register slave. Option words come from non-volatile storage outside
// this clock domain; the supply comparator output is an asynchronous level.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`default_nettype none
// Summary of operation
// - Codes 000/001: external RC, pin gpio/clock
// - Codes 010/011: internal RC, pin gpio/clock
// - 110 slow crystal; 111 fast crystal default
// - Internal RC frees second oscillator pin
// - Crystal modes: both oscillator pins dedicated
// - Internal RC default 4MHz, alternatives selectable
// - RC select 11/10/01/00: 4M/8M/1M/455k
// - Word0 bits 10:9 pick brownout level
// - Detector levels 2.2/3.3/4.0/4.5 volts
// - Detector disabled: no threshold, flag zero
// - Threshold crossing while enabled sets flag
// - Read-only status low while supply low and detector enabled
// - Flag bit 6: software clears, never sets
// - Wake register flag read returns flag AND mask; status register read returns raw flag
// - Flag cleared by software or reset
// - Reset: control 0x03, wake register zero
// - Wake register bit 5 enables wake-up
// - Mask register bit 6 enables interrupt
module css_top
  import css_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire css_pkg::css_ax_t s_axi_aw,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire css_pkg::css_w_t s_axi_w,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire css_pkg::css_ax_t s_axi_ar,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output css_pkg::css_r_t s_axi_r,
  // Non-volatile options and analog comparator
  input wire css_pkg::css_options_t optionWords,
  input wire logic supplyBelowLevel,
  // Configuration outputs
  output logic cfgReady,
  output css_pkg::css_clk_cfg_t clockCfg,
  output logic [13:0] rcFreqKhz,
  output css_pkg::css_brownout_t brownoutCfg,
  // Detector outputs
  output logic detectorOn,
  output logic [12:0] detectLevelMv,
  output logic supplyOkStatus_n,
  output logic wakeRequest,
  output logic irq
);
  import css_pkg::*;

  // ==========================================================================
  // Decode functions
  function automatic css_clk_cfg_t decodeClock(input logic [2:0] osc);
    css_clk_cfg_t c;
    c = '{mode: CSS_HXT, clkOnPinA: 1'b0, pinAGpio: 1'b0, pinBGpio: 1'b0};
    unique case (osc)
      3'h0: c = '{mode: CSS_ERC, clkOnPinA: 1'b0, pinAGpio: 1'b1, pinBGpio: 1'b0};
      3'h1: c = '{mode: CSS_ERC, clkOnPinA: 1'b1, pinAGpio: 1'b0, pinBGpio: 1'b0};
      3'h2: c = '{mode: CSS_IRC, clkOnPinA: 1'b0, pinAGpio: 1'b1, pinBGpio: 1'b1};
      3'h3: c = '{mode: CSS_IRC, clkOnPinA: 1'b1, pinAGpio: 1'b0, pinBGpio: 1'b1};
      3'h6: c.mode = CSS_LXT;
      // Unlisted codes fall back to the unprogrammed fast crystal setting
      default: c.mode = CSS_HXT;
    endcase
    return c;
  endfunction

  function automatic logic [13:0] decodeRcFreq(input logic [1:0] rcm);
    logic [13:0] f;
    f = 14'h0fa0;
    unique case (rcm)
      2'h3: f = 14'h0fa0; // 4000 kHz
      2'h2: f = 14'h1f40; // 8000 kHz
      2'h1: f = 14'h03e8; // 1000 kHz
      2'h0: f = 14'h01c7; // 455 kHz
    endcase
    return f;
  endfunction

  function automatic css_brownout_t decodeBrownout(input logic [1:0] lvr);
    css_brownout_t b;
    b = '{enable: 1'b0, levelMv: 13'h0000};
    unique case (lvr)
      2'h3: b = '{enable: 1'b0, levelMv: 13'h0000};
      2'h2: b = '{enable: 1'b1, levelMv: 13'h09c4}; // 2500 mV
      2'h1: b = '{enable: 1'b1, levelMv: 13'h0bb8}; // 3000 mV
      2'h0: b = '{enable: 1'b1, levelMv: 13'h0fa0}; // 4000 mV
    endcase
    return b;
  endfunction

  function automatic logic [12:0] decodeDetect(input logic [7:0] ctrl);
    logic [12:0] v;
    v = 13'h0000;
    if (ctrl[CTRL_EN_BIT]) begin
      unique case (ctrl[1:0])
        2'h3: v = 13'h0898; // 2200 mV
        2'h2: v = 13'h0ce4; // 3300 mV
        2'h1: v = 13'h0fa0; // 4000 mV
        2'h0: v = 13'h1194; // 4500 mV
      endcase
    end
    return v;
  endfunction

  function automatic logic isReg(input logic [31:0] addr, input logic [31:0] off);
    return addr[31:2] == off[31:2];
  endfunction

  // ==========================================================================
  // Reset synchroniser: asserts at once, releases after two edges
  logic rstMeta_n;
  logic rstSync_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ==========================================================================
  // State
  typedef struct packed {
    css_options_t optMeta;
    css_options_t optSync;
    logic belowMeta;
    logic belowSync;
    logic belowPrev;
    logic [1:0] capCnt;
    logic cfgValid;
    css_clk_cfg_t clk;
    logic [13:0] rcFreq;
    css_brownout_t bor;
    logic [7:0] ctrl;
    logic [7:0] wake;
    logic flag;
    logic [7:0] mask;
    logic [12:0] detLevel;
    logic awHeld;
    logic [31:0] awAddr;
    logic wHeld;
    css_w_t wBeat;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    css_r_t rBeat;
  } css_state_t;

  localparam css_state_t STATE_RST = '{
    optMeta: '0, optSync: '0, belowMeta: 1'b0, belowSync: 1'b0, belowPrev: 1'b0,
    capCnt: 2'h0, cfgValid: 1'b0,
    clk: '{mode: CSS_HXT, clkOnPinA: 1'b0, pinAGpio: 1'b0, pinBGpio: 1'b0},
    rcFreq: 14'h0fa0, bor: '{enable: 1'b0, levelMv: 13'h0000},
    ctrl: CTRL_RST, wake: WAKE_RST, flag: 1'b0, mask: MASK_RST, detLevel: 13'h0000,
    awHeld: 1'b0, awAddr: '0, wHeld: 1'b0, wBeat: '0, bValid: 1'b0, bResp: RESP_OKAY,
    rValid: 1'b0, rBeat: '0
  };

  css_state_t st;
  css_state_t nx;
  logic crossing;
  logic wrFire;
  logic [7:0] wrByte;

  assign crossing = st.ctrl[CTRL_EN_BIT] && (st.belowSync != st.belowPrev);
  assign wrFire = st.awHeld && st.wHeld && !st.bValid;
  assign wrByte = st.wBeat.data[7:0];

  always_comb begin
    nx = st;
    // Synchronisers; first stages are read only by second stages
    nx.optMeta = optionWords;
    nx.optSync = st.optMeta;
    nx.belowMeta = supplyBelowLevel;
    nx.belowSync = st.belowMeta;
    nx.belowPrev = st.belowSync;
    // Options are captured once the synchroniser holds settled values
    if (!st.cfgValid) begin
      if (st.capCnt == OPT_SETTLE) begin
        nx.cfgValid = 1'b1;
        nx.clk = decodeClock(st.optSync.word0[W0_OSC_LSB +: 3]);
        nx.rcFreq = decodeRcFreq(st.optSync.word1[W1_RCM_LSB +: 2]);
        nx.bor = decodeBrownout(st.optSync.word0[W0_LVR_LSB +: 2]);
      end else begin
        nx.capCnt = st.capCnt + 2'h1;
      end
    end
    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nx.awHeld = 1'b1;
      nx.awAddr = s_axi_aw.addr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nx.wHeld = 1'b1;
      nx.wBeat = s_axi_w;
    end
    if (st.bValid && s_axi_bready) begin
      nx.bValid = 1'b0;
    end
    if (wrFire) begin
      nx.awHeld = 1'b0;
      nx.wHeld = 1'b0;
      nx.bValid = 1'b1;
      nx.bResp = RESP_OKAY;
      if (isReg(st.awAddr, OFF_CTRL)) begin
        if (st.wBeat.strb[0]) begin
          nx.ctrl = wrByte;
        end
      end else if (isReg(st.awAddr, OFF_PORT8)) begin
        // Enable is shared with the control register; status bit is read-only
        if (st.wBeat.strb[0]) begin
          nx.ctrl[CTRL_EN_BIT] = wrByte[PORT8_EN_BIT];
        end
      end else if (isReg(st.awAddr, OFF_WAKE)) begin
        if (st.wBeat.strb[0]) begin
          nx.wake = wrByte & WAKE_RW_MASK;
          if (!wrByte[WAKE_FLAG_BIT]) begin
            nx.flag = 1'b0;
          end
        end
      end else if (isReg(st.awAddr, OFF_MASK)) begin
        if (st.wBeat.strb[0]) begin
          nx.mask = wrByte & MASK_RW_MASK;
        end
      end else if (isReg(st.awAddr, OFF_IRQSTAT)) begin
        if (st.wBeat.strb[0] && wrByte[WAKE_FLAG_BIT]) begin
          nx.flag = 1'b0;
        end
      end else if (!isReg(st.awAddr, OFF_CFG)) begin
        nx.bResp = RESP_DECERR;
      end
    end
    // A crossing in the same cycle as a clear still leaves the flag set
    if (crossing) begin
      nx.flag = 1'b1;
    end
    if (!nx.ctrl[CTRL_EN_BIT]) begin
      nx.flag = 1'b0;
    end
    nx.detLevel = decodeDetect(nx.ctrl);
    // Read channel: one outstanding read, data registered at acceptance
    if (st.rValid && s_axi_rready) begin
      nx.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nx.rValid = 1'b1;
      nx.rBeat = '{data: 32'h0000_0000, resp: RESP_OKAY};
      if (isReg(s_axi_ar.addr, OFF_CTRL)) begin
        nx.rBeat.data[7:0] = st.ctrl;
      end else if (isReg(s_axi_ar.addr, OFF_PORT8)) begin
        nx.rBeat.data[PORT8_EN_BIT] = st.ctrl[CTRL_EN_BIT];
        nx.rBeat.data[PORT8_OKN_BIT] = supplyOkStatus_n;
      end else if (isReg(s_axi_ar.addr, OFF_WAKE)) begin
        nx.rBeat.data[7:0] = st.wake;
        nx.rBeat.data[WAKE_FLAG_BIT] = st.flag & st.mask[MASK_IE_BIT];
      end else if (isReg(s_axi_ar.addr, OFF_MASK)) begin
        nx.rBeat.data[7:0] = st.mask;
      end else if (isReg(s_axi_ar.addr, OFF_IRQSTAT)) begin
        nx.rBeat.data[WAKE_FLAG_BIT] = st.flag;
      end else if (isReg(s_axi_ar.addr, OFF_CFG)) begin
        nx.rBeat.data[3:0] = st.clk.mode;
        nx.rBeat.data[4] = st.clk.clkOnPinA;
        nx.rBeat.data[5] = st.clk.pinAGpio;
        nx.rBeat.data[6] = st.clk.pinBGpio;
        nx.rBeat.data[7] = st.bor.enable;
        nx.rBeat.data[8] = st.cfgValid;
      end else begin
        nx.rBeat.resp = RESP_DECERR;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st <= STATE_RST;
    end else begin
      st <= nx;
    end
  end

  // ==========================================================================
  // Outputs
  assign s_axi_awready = !st.awHeld;
  assign s_axi_wready = !st.wHeld;
  assign s_axi_bvalid = st.bValid;
  assign s_axi_bresp = st.bResp;
  assign s_axi_arready = !st.rValid;
  assign s_axi_rvalid = st.rValid;
  assign s_axi_r = st.rBeat;
  assign cfgReady = st.cfgValid;
  assign clockCfg = st.clk;
  assign rcFreqKhz = st.rcFreq;
  assign brownoutCfg = st.bor;
  assign detectorOn = st.ctrl[CTRL_EN_BIT];
  assign detectLevelMv = st.detLevel;
  assign supplyOkStatus_n = !(st.ctrl[CTRL_EN_BIT] && st.belowSync);
  assign wakeRequest = st.flag && st.wake[WAKE_WE_BIT];
  assign irq = st.flag && st.mask[MASK_IE_BIT];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSync_n);

  sequence seqWriteIssued;
    wrFire;
  endsequence
  sequence seqRespShown;
    s_axi_bvalid;
  endsequence
  sequence seqWakeRead;
    s_axi_arvalid && s_axi_arready && isReg(s_axi_ar.addr, OFF_WAKE);
  endsequence

  chk_flag_sets: assert property (crossing |=> st.flag || !st.ctrl[CTRL_EN_BIT])
    else $error("crossing did not set the drop flag");
  chk_flag_off_idle: assert property (!st.ctrl[CTRL_EN_BIT] |-> !st.flag && !irq && !wakeRequest)
    else $error("drop flag set while detector disabled");
  chk_status_low: assert property (st.ctrl[CTRL_EN_BIT] && st.belowSync |-> !supplyOkStatus_n)
    else $error("status not low while supply low");
  chk_status_idle: assert property (!st.ctrl[CTRL_EN_BIT] |-> supplyOkStatus_n)
    else $error("status low while detector off");
  chk_read_masked: assert property (seqWakeRead |=> s_axi_r.data[WAKE_FLAG_BIT] ==
    ($past(st.flag) && $past(st.mask[MASK_IE_BIT])))
    else $error("flag read not gated by mask");
  chk_sw_noset: assert property (wrFire && !st.flag && !crossing |=> !st.flag)
    else $error("software write set the drop flag");
  chk_sw_clear: assert property (wrFire && isReg(st.awAddr, OFF_WAKE) && st.wBeat.strb[0]
    && !wrByte[WAKE_FLAG_BIT] && !crossing |=> !st.flag)
    else $error("software clear of drop flag lost");
  chk_irq_level: assert property ($rose(irq) |-> $past(crossing) || $past(wrFire))
    else $error("interrupt rose without crossing or bus write");
  chk_cfg_static: assert property (st.cfgValid ##1 1'b1 |-> $stable(clockCfg) && $stable(rcFreqKhz)
    && $stable(brownoutCfg))
    else $error("option decode changed while running");
  chk_crystal_pins: assert property (clockCfg.mode inside {CSS_LXT, CSS_HXT} |->
    !clockCfg.pinAGpio && !clockCfg.pinBGpio && !clockCfg.clkOnPinA)
    else $error("crystal mode released an oscillator pin");
  chk_write_resp: assert property (seqWriteIssued |=> seqRespShown)
    else $error("write response missing");
  // Only a crossing may raise the flag; bus writes can merely clear it
  chk_flag_source: assert property ($rose(st.flag) |-> $past(crossing))
    else $error("drop flag rose without a crossing");
  chk_w1c_clear: assert property (wrFire && isReg(st.awAddr, OFF_IRQSTAT) && st.wBeat.strb[0]
    && wrByte[WAKE_FLAG_BIT] && !crossing |=> !st.flag)
    else $error("status register clear of drop flag lost");
  chk_status_high: assert property (st.ctrl[CTRL_EN_BIT] && !st.belowSync |-> supplyOkStatus_n)
    else $error("status low while supply good");
  chk_wake_rise: assert property ($rose(wakeRequest) |-> $past(crossing) || $past(wrFire))
    else $error("wake request rose without cause");
  chk_irc_pinb: assert property (clockCfg.mode == CSS_IRC |-> clockCfg.pinBGpio)
    else $error("internal RC mode kept second pin");
  chk_pin_a_role: assert property (clockCfg.clkOnPinA |-> !clockCfg.pinAGpio)
    else $error("shared pin both clock and gpio");
  chk_det_level: assert property (st.ctrl[CTRL_EN_BIT] |-> detectLevelMv != 13'h0000)
    else $error("enabled detector has no level");
  chk_cfg_settle: assert property ($rose(cfgReady) |-> st.capCnt == OPT_SETTLE)
    else $error("options captured before settling");
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the clock and supply supervision block.
// Drives the AXI4-Lite slave, the option words and the comparator level itself.
`default_nettype none
module tb
  import css_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Stimulus and observed signals
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  css_ax_t s_axi_aw = '0;
  css_ax_t s_axi_ar = '0;
  css_w_t s_axi_w = '0;
  css_options_t optionWords = '0;
  logic supplyBelowLevel = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cfgReady;
  logic detectorOn, supplyOkStatus_n, wakeRequest, irq;
  logic [1:0] s_axi_bresp;
  css_r_t s_axi_r;
  css_clk_cfg_t clockCfg;
  logic [13:0] rcFreqKhz;
  css_brownout_t brownoutCfg;
  logic [12:0] detectLevelMv;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] seed = 32'h0000c1bc;
  css_r_t rdq[$];
  logic [1:0] wrq[$];
  css_r_t rdExp;
  // Expected decodes: {mode, clkOnPinA, pinAGpio, pinBGpio} and frequencies
  logic [2:0] oscTab [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [6:0] clkTab [8] = '{7'h0a, 7'h0c, 7'h13, 7'h15, 7'h40, 7'h40, 7'h20, 7'h40};
  logic [13:0] rcTab [4] = '{14'h01c7, 14'h03e8, 14'h1f40, 14'h0fa0};
  logic [13:0] lvrTab [4] = '{14'h2fa0, 14'h2bb8, 14'h29c4, 14'h0000};
  logic [12:0] detTab [4] = '{13'h1194, 13'h0fa0, 13'h0ce4, 13'h0898};

  always #10 core_clk = ~core_clk;

  css_top uut (
    .core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_aw(s_axi_aw),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_w(s_axi_w),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_ar(s_axi_ar),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_r(s_axi_r),
    .optionWords(optionWords), .supplyBelowLevel(supplyBelowLevel), .cfgReady(cfgReady),
    .clockCfg(clockCfg), .rcFreqKhz(rcFreqKhz), .brownoutCfg(brownoutCfg), .detectorOn(detectorOn),
    .detectLevelMv(detectLevelMv), .supplyOkStatus_n(supplyOkStatus_n), .wakeRequest(wakeRequest), .irq(irq)
  );
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic endtest(input string name);
    $display("test %s done", name);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================================
  // Bus master; handshakes are judged at the falling edge so ready has settled
  task automatic axi_write(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r);
    logic awTake;
    logic wTake;
    logic bTake;
    wrq.push_back(r);
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_aw <= '{addr: a, prot: 3'h0};
    s_axi_wvalid <= 1'b1;
    s_axi_w <= '{data: (xorshift() & 32'hffffff00) | {24'h0, d}, strb: 4'h1};
    s_axi_bready <= 1'b1;
    do begin
      @(negedge core_clk);
      awTake = s_axi_awvalid && s_axi_awready;
      wTake = s_axi_wvalid && s_axi_wready;
      bTake = s_axi_bvalid && s_axi_bready;
      @(posedge core_clk);
      if (awTake) s_axi_awvalid <= 1'b0;
      if (wTake) s_axi_wvalid <= 1'b0;
    end while (!bTake);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    logic arTake;
    logic rTake;
    rdq.push_back('{data: d, resp: r});
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_ar <= '{addr: a, prot: 3'h0};
    s_axi_rready <= 1'b1;
    do begin
      @(negedge core_clk);
      arTake = s_axi_arvalid && s_axi_arready;
      rTake = s_axi_rvalid && s_axi_rready;
      @(posedge core_clk);
      if (arTake) s_axi_arvalid <= 1'b0;
    end while (!rTake);
    s_axi_rready <= 1'b0;
  endtask

  // Response monitor: each accepted answer is matched with the oldest note
  always @(negedge core_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      if (rdq.size() > 0) begin
        rdExp = rdq.pop_front();
        chk(s_axi_r.data, rdExp.data);
        chk(32'(s_axi_r.resp), 32'(rdExp.resp));
      end else chk(32'h1, 32'h0);
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      if (wrq.size() > 0) chk(32'(s_axi_bresp), 32'(wrq.pop_front()));
      else chk(32'h1, 32'h0);
    end
  end

  // This task changes options only under reset; ignored option bits get random values
  task automatic do_reset(input logic [2:0] osc, input logic [1:0] rcm, input logic [1:0] lvr);
    logic [31:0] rnd;
    rnd = xorshift();
    @(posedge core_clk);
    rst_n <= 1'b0;
    optionWords <= '{word0: {rnd[12:11], lvr, rnd[8:7], osc, rnd[3:0]}, word1: {rnd[24:14], rcm}};
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge core_clk);
  endtask

  // Comparator output passes two sync flops before it counts
  task automatic set_supply(input logic v);
    @(posedge core_clk);
    supplyBelowLevel <= v;
    repeat (5) @(posedge core_clk);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 8; i++) begin
      do_reset(oscTab[i], 2'(i), 2'(i));
      chk(32'(cfgReady), 32'h1);
      chk(32'(clockCfg), 32'(clkTab[i]));
      chk(32'(rcFreqKhz), 32'(rcTab[i % 4]));
      chk(32'(brownoutCfg), 32'(lvrTab[i % 4]));
      endtest("options");
    end
    axi_read(OFF_CFG, 32'h108, RESP_OKAY);
    @(posedge core_clk);
    optionWords <= '0;
    repeat (10) @(posedge core_clk);
    chk(32'(clockCfg), 32'h40);
    endtest("option hold");
    axi_read(OFF_CTRL, 32'h03, RESP_OKAY);
    axi_read(OFF_WAKE, 32'h00, RESP_OKAY);
    axi_read(OFF_MASK, 32'h00, RESP_OKAY);
    axi_read(OFF_PORT8, 32'h40, RESP_OKAY);
    endtest("reset values");
    for (int l = 0; l < 4; l++) begin
      axi_write(OFF_CTRL, {6'h01, 2'(l)}, RESP_OKAY);
      repeat (2) @(posedge core_clk);
      chk(32'(detectorOn), 32'h1);
      chk(32'(detectLevelMv), 32'(detTab[l]));
    end
    axi_read(OFF_PORT8, 32'hc0, RESP_OKAY);
    endtest("detector levels");
    axi_write(OFF_MASK, 8'h40, RESP_OKAY);
    axi_write(OFF_WAKE, 8'h60, RESP_OKAY);
    axi_read(OFF_WAKE, 32'h20, RESP_OKAY);
    set_supply(1'b1);
    chk(32'(supplyOkStatus_n), 32'h0);
    chk(32'(irq), 32'h1);
    chk(32'(wakeRequest), 32'h1);
    axi_read(OFF_PORT8, 32'h80, RESP_OKAY);
    axi_read(OFF_WAKE, 32'h60, RESP_OKAY);
    axi_write(OFF_WAKE, 8'h20, RESP_OKAY);
    axi_read(OFF_IRQSTAT, 32'h00, RESP_OKAY);
    chk(32'(irq), 32'h0);
    chk(32'(wakeRequest), 32'h0);
    set_supply(1'b0);
    axi_read(OFF_IRQSTAT, 32'h40, RESP_OKAY);
    axi_write(OFF_IRQSTAT, 8'h40, RESP_OKAY);
    axi_read(OFF_IRQSTAT, 32'h00, RESP_OKAY);
    axi_write(OFF_MASK, 8'h00, RESP_OKAY);
    set_supply(1'b1);
    chk(32'(irq), 32'h0);
    axi_read(OFF_WAKE, 32'h20, RESP_OKAY);
    axi_read(OFF_IRQSTAT, 32'h40, RESP_OKAY);
    endtest("flag");
    axi_write(OFF_CTRL, 8'h03, RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk(32'(detectorOn), 32'h0);
    chk(32'(detectLevelMv), 32'h0);
    chk(32'(supplyOkStatus_n), 32'h1);
    axi_read(OFF_IRQSTAT, 32'h00, RESP_OKAY);
    set_supply(1'b0);
    axi_read(OFF_IRQSTAT, 32'h00, RESP_OKAY);
    axi_read(OFF_PORT8, 32'h40, RESP_OKAY);
    endtest("detector off");
    // A pending flag and written registers must not survive a reset
    axi_write(OFF_CTRL, 8'h07, RESP_OKAY);
    set_supply(1'b1);
    axi_read(OFF_IRQSTAT, 32'h40, RESP_OKAY);
    do_reset(3'h7, 2'h3, 2'h3);
    axi_read(OFF_IRQSTAT, 32'h00, RESP_OKAY);
    axi_read(OFF_CTRL, 32'h03, RESP_OKAY);
    axi_read(OFF_WAKE, 32'h00, RESP_OKAY);
    endtest("reset clears");
    axi_write(32'h0000_0020, 8'hff, RESP_DECERR);
    axi_read(32'h0000_0020, 32'h0, RESP_DECERR);
    axi_write(OFF_CFG, 8'h00, RESP_OKAY);
    axi_read(OFF_CFG, 32'h108, RESP_OKAY);
    endtest("decode");
    chk(32'(rdq.size() + wrq.size()), 32'h0);
    give_verdict();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
